// file: fpe_cfg.svh
// Constants for the flash program/erase controller.
// Assumes inclusion by bare name from the package and the top module.
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
`define FPE_MAIN_BYTES 65536
`define FPE_SCRATCH_BYTES 128
`define FPE_PAGE_BYTES 512
`define FPE_ERASED_BYTE 8'hff
`define FPE_PSC_WRITE_EN_BIT 0
`define FPE_PSC_ERASE_EN_BIT 1
`define FPE_SCALE_WE_EN_BIT 0
`define FPE_CLK_MHZ 200
`define FPE_ERASE_MIN_US 10000
`define FPE_ERASE_MAX_US 14000
`define FPE_PROG_MIN_US 40
`define FPE_PROG_MAX_US 60
// Aim at the typical midpoint of each window
`define FPE_ERASE_TYP_US 12000
`define FPE_PROG_TYP_US 50
`define FPE_ERASE_CYCLES (`FPE_ERASE_TYP_US * `FPE_CLK_MHZ)
`define FPE_PROG_CYCLES (`FPE_PROG_TYP_US * `FPE_CLK_MHZ)
`endif

// file: fpe_pkg.sv
// Types for the flash program/erase controller.
// Assumes fpe_cfg.svh is on the include path.
`include "fpe_cfg.svh"
package fpe_pkg;
  typedef logic [16:0] fpe_addr_t;
  typedef logic [7:0] fpe_byte_t;
  typedef enum logic [3:0] {
    FPE_IDLE = 4'h1,
    FPE_PROG = 4'h2,
    FPE_ERASE = 4'h4,
    FPE_DONE = 4'h8
  } fpe_state_e;
endpackage : fpe_pkg

// file: fpe_timer_if.sv
// Interface between the sequencer and its operation timer.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface fpe_timer_if;
  logic start;
  logic [31:0] load;
  logic busy;
  logic expired;
  modport ctrl (output start, output load, input busy, input expired);
  modport tmr (input start, input load, output busy, output expired);
endinterface : fpe_timer_if

// file: fpe_timer.sv
// Down-counter that times one program or erase operation.
// Assumes a start pulse with load held valid in that cycle.
`timescale 1ns/1ps
module fpe_timer (
  input wire logic clk,
  input wire logic rst_n,
  fpe_timer_if.tmr t
);
  import fpe_pkg::*;
  logic [31:0] cnt_ff;
  logic busy_ff;
  logic exp_ff;

  // Count runs to one, then one expiry pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      busy_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else begin
      exp_ff <= 1'b0;
      if (t.start) begin
        cnt_ff <= t.load;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff <= 32'h1) begin
          busy_ff <= 1'b0;
          exp_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 32'h1;
        end
      end
    end
  end

  assign t.busy = busy_ff;
  assign t.expired = exp_ff;
endmodule : fpe_timer

// file: fpe_flash_ctrl.sv
// Flash program/erase sequencer with its own byte array.
// Assumes the core holds a request one cycle and stalls on CORE_STALL.
//
// Function
// - Holds 64k plus 128 bytes, each programmable one byte per operation by software or test port.
// - Programming only clears bits, by ANDing new data into the stored byte.
// - Erase sets every byte of the addressed 512-byte page to all ones.
// - Operations are timed internally and end without any polling.
// - With write enable set, data-move writes go to flash not data RAM.
// - Write enable stays set until software clears it.
// - Data-move reads always go to data RAM; flash reads only by code read.
// - Software writes and erases need the scale-register enable bit.
// - With erase and write enables set, a write erases its whole page.
// - A blank device can be programmed only through the test port.
// - The core stalls during an operation; interrupts are held pending.
// - Erase takes 10 to 14 ms, program 40 to 60 us, from the write.
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module fpe_flash_ctrl #(
  parameter int unsigned ERASE_CYCLES = `FPE_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES = `FPE_PROG_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic PSC_WR,
  input wire logic [1:0] PSC_WDATA,
  input wire logic SCALE_WR,
  input wire logic SCALE_WDATA,
  input wire logic XWR,
  input wire logic XRD,
  input wire fpe_pkg::fpe_addr_t XADDR,
  input wire fpe_pkg::fpe_byte_t XWDATA,
  input wire logic CODE_RD,
  input wire fpe_pkg::fpe_addr_t CODE_ADDR,
  input wire logic TP_WR,
  input wire logic TP_ERASE,
  input wire fpe_pkg::fpe_addr_t TP_ADDR,
  input wire fpe_pkg::fpe_byte_t TP_WDATA,
  output fpe_pkg::fpe_byte_t CODE_RDATA,
  output logic RAM_WR,
  output logic RAM_RD,
  output fpe_pkg::fpe_addr_t RAM_ADDR,
  output fpe_pkg::fpe_byte_t RAM_WDATA,
  output logic CORE_STALL,
  output logic INT_HOLD,
  output logic PSC_WE,
  output logic PSC_EE,
  output logic SCALE_WE
);
  import fpe_pkg::*;

  localparam int unsigned DEPTH = `FPE_MAIN_BYTES + `FPE_SCRATCH_BYTES;
  localparam int unsigned PAGE = `FPE_PAGE_BYTES;
  localparam int unsigned PAGE_BITS = $clog2(PAGE);

  logic rst_s1_ff;
  logic rst_s2_ff;
  logic rst_n;
  fpe_byte_t mem [DEPTH];
  fpe_state_e state_ff;
  fpe_state_e nxt_state;
  logic psc_we_ff;
  logic psc_ee_ff;
  logic scale_we_ff;
  fpe_addr_t op_addr_ff;
  fpe_byte_t op_data_ff;
  logic [PAGE_BITS:0] erase_idx_ff;
  logic erase_walk_ff;
  logic sw_prog;
  logic sw_erase;
  logic go_prog;
  logic go_erase;
  fpe_byte_t code_rdata_ff;
  logic ram_wr_ff;
  logic ram_rd_ff;
  fpe_addr_t ram_addr_ff;
  fpe_byte_t ram_wdata_ff;
  logic stall_ff;

  fpe_timer_if tif ();

  fpe_timer u_timer (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .t(tif.tmr)
  );

  // Reset release through two flops, assertion stays immediate
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  // Byte-address range check against the array depth; used for both request sources and code reads
  function automatic logic in_range(input fpe_addr_t a);
    in_range = (32'(a) < DEPTH);
  endfunction : in_range

  // Redirected writes need both enables; a clear scale bit drops them
  assign sw_prog = XWR && psc_we_ff && !psc_ee_ff && scale_we_ff;
  assign sw_erase = XWR && psc_we_ff && psc_ee_ff && scale_we_ff;
  // Test port bypasses software enables so a blank part can load
  assign go_prog = (state_ff == FPE_IDLE) &&
                   ((sw_prog && in_range(XADDR)) ||
                    (TP_WR && !TP_ERASE && in_range(TP_ADDR)));
  assign go_erase = (state_ff == FPE_IDLE) &&
                    ((sw_erase && in_range(XADDR)) ||
                     (TP_WR && TP_ERASE && in_range(TP_ADDR)));

  // Control bits held until software rewrites them
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      psc_we_ff <= 1'b0;
      psc_ee_ff <= 1'b0;
      scale_we_ff <= 1'b0;
    end else begin
      if (PSC_WR) begin
        psc_we_ff <= PSC_WDATA[`FPE_PSC_WRITE_EN_BIT];
        psc_ee_ff <= PSC_WDATA[`FPE_PSC_ERASE_EN_BIT];
      end
      if (SCALE_WR) begin
        scale_we_ff <= SCALE_WDATA;
      end
    end
  end

  // Sequencer: idle, timed operation, one cycle of completion
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FPE_IDLE: begin
        if (go_erase) begin
          nxt_state = FPE_ERASE;
        end else if (go_prog) begin
          nxt_state = FPE_PROG;
        end
      end
      FPE_PROG, FPE_ERASE: begin
        if (tif.expired) begin
          nxt_state = FPE_DONE;
        end
      end
      FPE_DONE: nxt_state = FPE_IDLE;
      default: nxt_state = FPE_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= FPE_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Timer load chosen by operation kind
  assign tif.start = go_prog || go_erase;
  assign tif.load = go_erase ? ERASE_CYCLES : PROG_CYCLES;

  // Latch address and data; software source wins on a tie
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      op_addr_ff <= 17'h0;
      op_data_ff <= 8'h0;
    end else if (go_prog || go_erase) begin
      if (sw_prog || sw_erase) begin
        op_addr_ff <= XADDR;
        op_data_ff <= XWDATA;
      end else begin
        op_addr_ff <= TP_ADDR;
        op_data_ff <= TP_WDATA;
      end
    end
  end

  // Erase walks the page one byte per cycle, well inside the timed window
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      erase_idx_ff <= '0;
      erase_walk_ff <= 1'b0;
    end else if (go_erase) begin
      erase_idx_ff <= '0;
      erase_walk_ff <= 1'b1;
    end else if (erase_walk_ff) begin
      erase_idx_ff <= erase_idx_ff + 1'b1;
      if (erase_idx_ff == (PAGE_BITS + 1)'(PAGE - 1)) begin
        erase_walk_ff <= 1'b0;
      end
    end
  end

  // Array update; no reset so it maps onto a memory
  always_ff @(posedge CORE_CLK) begin
    if (erase_walk_ff) begin
      mem[{op_addr_ff[16:PAGE_BITS], erase_idx_ff[PAGE_BITS-1:0]}] <=
        `FPE_ERASED_BYTE;
    end else if (state_ff == FPE_PROG && tif.expired) begin
      mem[op_addr_ff] <= mem[op_addr_ff] & op_data_ff;
    end
  end

  // Code reads are the only read path out of the array
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      code_rdata_ff <= 8'h0;
    end else if (CODE_RD && in_range(CODE_ADDR)) begin
      code_rdata_ff <= mem[CODE_ADDR];
    end
  end

  // Data RAM path: reads always pass, writes pass only while write enable is clear
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ram_wr_ff <= 1'b0;
      ram_rd_ff <= 1'b0;
      ram_addr_ff <= 17'h0;
      ram_wdata_ff <= 8'h0;
    end else begin
      ram_wr_ff <= XWR && !psc_we_ff;
      ram_rd_ff <= XRD;
      ram_addr_ff <= XADDR;
      ram_wdata_ff <= XWDATA;
    end
  end

  // Stall covers the done cycle too, so no request is lost while low
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= (nxt_state != FPE_IDLE);
    end
  end

  assign CODE_RDATA = code_rdata_ff;
  assign RAM_WR = ram_wr_ff;
  assign RAM_RD = ram_rd_ff;
  assign RAM_ADDR = ram_addr_ff;
  assign RAM_WDATA = ram_wdata_ff;
  assign CORE_STALL = stall_ff;
  assign INT_HOLD = stall_ff;
  assign PSC_WE = psc_we_ff;
  assign PSC_EE = psc_ee_ff;
  assign SCALE_WE = scale_we_ff;
endmodule : fpe_flash_ctrl

// file: fpe_flash_ctrl_asserts.sv
// Checker for the flash program/erase controller top ports.
// Assumes one clock domain and a bind by port name.
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module fpe_flash_ctrl_asserts #(
  parameter int unsigned ERASE_CYCLES = 600,
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic PSC_WR,
  input wire logic [1:0] PSC_WDATA,
  input wire logic SCALE_WE,
  input wire logic XWR,
  input wire logic XRD,
  input wire fpe_pkg::fpe_addr_t XADDR,
  input wire fpe_pkg::fpe_byte_t XWDATA,
  input wire logic TP_WR,
  input wire fpe_pkg::fpe_addr_t TP_ADDR,
  input wire logic RAM_WR,
  input wire logic RAM_RD,
  input wire fpe_pkg::fpe_addr_t RAM_ADDR,
  input wire fpe_pkg::fpe_byte_t RAM_WDATA,
  input wire logic CORE_STALL,
  input wire logic INT_HOLD,
  input wire logic PSC_WE,
  input wire logic PSC_EE
);
  import fpe_pkg::*;
  // Requests above the array are ignored by the design
  localparam int unsigned DEPTH = `FPE_MAIN_BYTES + `FPE_SCRATCH_BYTES;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  logic [31:0] stall_cnt_ff;
  // Stall length, so one counter serves both operation kinds
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) stall_cnt_ff <= '0;
    else if (CORE_STALL) stall_cnt_ff <= stall_cnt_ff + 32'h1;
    else stall_cnt_ff <= '0;
  end
  sw_stall_a: assert property (XWR && PSC_WE && SCALE_WE && !CORE_STALL
    && 32'(XADDR) < DEPTH |=> CORE_STALL)
    else $error("no stall after write");
  tp_stall_a: assert property (TP_WR && !CORE_STALL
    && 32'(TP_ADDR) < DEPTH |=> CORE_STALL)
    else $error("no stall after test port op");
  no_enable_a: assert property (XWR && !SCALE_WE && !TP_WR && !CORE_STALL
    |=> !CORE_STALL) else $error("op without enable");
  redirect_a: assert property (XWR && PSC_WE && !CORE_STALL
    |=> !RAM_WR) else $error("redirected write hit data ram");
  ram_write_a: assert property (XWR && !PSC_WE && !CORE_STALL |=> RAM_WR
    && RAM_ADDR == $past(XADDR) && RAM_WDATA == $past(XWDATA))
    else $error("data ram write lost");
  ram_read_a: assert property (XRD && !CORE_STALL |=> RAM_RD
    && RAM_ADDR == $past(XADDR)) else $error("read not sent to data ram");
  we_hold_a: assert property (PSC_WE && !PSC_WR |=> PSC_WE)
    else $error("write enable dropped");
  psc_load_a: assert property (PSC_WR && !CORE_STALL
    |=> {PSC_EE, PSC_WE} == $past(PSC_WDATA)) else $error("enables wrong");
  int_hold_a: assert property (INT_HOLD == CORE_STALL)
    else $error("interrupt hold not tied to stall");
  op_len_a: assert property ($fell(CORE_STALL) |->
    (stall_cnt_ff >= PROG_CYCLES && stall_cnt_ff <= PROG_CYCLES + 4) ||
    (stall_cnt_ff >= ERASE_CYCLES && stall_cnt_ff <= ERASE_CYCLES + 4))
    else $error("operation length wrong");
  op_end_a: assert property (stall_cnt_ff <= ERASE_CYCLES + 4)
    else $error("operation never ends");
  cover property (XWR && PSC_WE && PSC_EE && SCALE_WE && !CORE_STALL);
  cover property (XWR && PSC_WE && !PSC_EE && SCALE_WE && !CORE_STALL);
  cover property (TP_WR && !CORE_STALL);
endmodule : fpe_flash_ctrl_asserts

bind fpe_flash_ctrl fpe_flash_ctrl_asserts #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)) i_chk (.*);

// file: fpe_external_data_ram_mdl.sv
// Data ram model on the far side of the data-move path.
// Assumes registered requests on the system clock.
`timescale 1ns/1ps
module fpe_ram_mdl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic rd,
  input wire fpe_pkg::fpe_addr_t addr,
  input wire fpe_pkg::fpe_byte_t wdata,
  output int wr_cnt,
  output int rd_cnt,
  output fpe_pkg::fpe_addr_t last_addr,
  output fpe_pkg::fpe_byte_t last_data
);
  import fpe_pkg::*;
  // Counts and last access, enough to see where traffic went
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt <= 0;
      rd_cnt <= 0;
      last_addr <= '0;
      last_data <= '0;
    end else begin
      if (wr) wr_cnt <= wr_cnt + 1;
      if (rd) rd_cnt <= rd_cnt + 1;
      if (wr || rd) last_addr <= addr;
      if (wr) last_data <= wdata;
    end
  end
endmodule : fpe_ram_mdl

// file: tb_top.sv
// Testbench for the flash program/erase controller.
// Assumes short operation counts set by parameter.
`timescale 1ns/1ps
module tb_top;
  import fpe_pkg::*;
  localparam int P = 20;
  localparam int E = 600;
  logic CORE_CLK = 0, RESET_N = 0, PSC_WR = 0, SCALE_WR = 0;
  logic SCALE_WDATA = 0, XWR = 0, XRD = 0, CODE_RD = 0, TP_WR = 0;
  logic TP_ERASE = 0, RAM_WR, RAM_RD, CORE_STALL, INT_HOLD;
  logic PSC_WE, PSC_EE, SCALE_WE;
  logic [1:0] PSC_WDATA = '0;
  fpe_addr_t XADDR = '0, CODE_ADDR = '0, TP_ADDR = '0, RAM_ADDR, m_addr;
  fpe_byte_t XWDATA = '0, TP_WDATA = '0, CODE_RDATA, RAM_WDATA, m_data;
  int mismatches = 0, total_checks = 0, wr_cnt, rd_cnt;
  always #2.5 CORE_CLK = ~CORE_CLK;
  fpe_flash_ctrl #(.ERASE_CYCLES(E), .PROG_CYCLES(P)) i_dut (.*);
  fpe_ram_mdl i_ram (.clk(CORE_CLK), .rst_n(RESET_N), .wr(RAM_WR),
    .rd(RAM_RD), .addr(RAM_ADDR), .wdata(RAM_WDATA), .wr_cnt(wr_cnt),
    .rd_cnt(rd_cnt), .last_addr(m_addr), .last_data(m_data));
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Inputs move 1 ns after the edge, clear of the sampling instant
  task step;
    @(posedge CORE_CLK);
    #1;
  endtask : step
  task wr_reg(input logic s, input logic [1:0] v);
    SCALE_WDATA = v[0];
    PSC_WDATA = v;
    SCALE_WR = s;
    PSC_WR = !s;
    step;
    SCALE_WR = 0;
    PSC_WR = 0;
  endtask : wr_reg
  task xwr(input fpe_addr_t a, input fpe_byte_t d);
    XADDR = a;
    XWDATA = d;
    XWR = 1;
    step;
    XWR = 0;
  endtask : xwr
  task tp(input logic er, input fpe_addr_t a, input fpe_byte_t d);
    TP_ERASE = er;
    TP_ADDR = a;
    TP_WDATA = d;
    TP_WR = 1;
    step;
    TP_WR = 0;
  endtask : tp
  // Bounded wait on the stall; its length must sit near the count
  task wait_op(input int lo);
    int n;
    n = 0;
    step;
    while (CORE_STALL === 1'b1 && n < 1000) begin
      n++;
      step;
    end
    if (n >= 1000) begin
      mismatches++;
      end_sim();
    end else begin
      chk(n >= lo && n <= lo + 4, 1);
    end
  endtask : wait_op
  task rd(input fpe_addr_t a, input fpe_byte_t e);
    CODE_ADDR = a;
    CODE_RD = 1;
    step;
    CODE_RD = 0;
    step;
    chk(CODE_RDATA, e);
  endtask : rd
  task t_ram;
    wr_reg(0, 2'h0);
    xwr(17'h00123, 8'ha5);
    repeat (2) step;
    chk({wr_cnt[7:0], m_addr, m_data}, {8'h01, 17'h00123, 8'ha5});
    wr_reg(0, 2'h1);
    XADDR = 17'h00456;
    XRD = 1;
    step;
    XRD = 0;
    repeat (2) step;
    chk({rd_cnt[7:0], m_addr}, {8'h01, 17'h00456});
    xwr(17'h00200, 8'h00);
    repeat (2) step;
    chk({CORE_STALL, wr_cnt[7:0]}, {1'b0, 8'h01});
  endtask : t_ram
  task t_sw;
    wr_reg(1, 2'h1);
    wr_reg(0, 2'h3);
    xwr(17'h00456, 8'h00);
    wait_op(E);
    wr_reg(0, 2'h1);
    xwr(17'h005ff, 8'h5a);
    wait_op(P);
    xwr(17'h005ff, 8'h0f);
    wait_op(P);
    rd(17'h005ff, 8'h0a);
    rd(17'h00400, 8'hff);
    chk(PSC_WE, 1);
    chk({SCALE_WE, PSC_EE}, 2'b10);
  endtask : t_sw
  task t_drop;
    wr_reg(1, 2'h0);
    xwr(17'h005ff, 8'h00);
    step;
    chk(CORE_STALL, 0);
    rd(17'h005ff, 8'h0a);
    wr_reg(0, 2'h0);
    chk(PSC_WE, 0);
    xwr(17'h00300, 8'h77);
    repeat (2) step;
    chk({wr_cnt[7:0], m_addr, m_data}, {8'h02, 17'h00300, 8'h77});
  endtask : t_drop
  task t_tp;
    tp(1, 17'h10010, 8'h00);
    wait_op(E);
    tp(0, 17'h1007f, 8'h3c);
    wait_op(P);
    rd(17'h1007f, 8'h3c);
    rd(17'h10000, 8'hff);
  endtask : t_tp
  initial begin
    repeat (6) @(posedge CORE_CLK);
    #1 RESET_N = 1;
    repeat (3) step;
    t_ram;
    t_sw;
    t_drop;
    t_tp;
    end_sim;
  end
endmodule : tb_top
